// ---- rtl/rx_word_store.v ----
// Small memory holding received data words, read data registered.
`timescale 1ns/1ps
module rx_word_store (
  clk_sys,
  wrEn,
  wrAddr,
  wrData,
  rdAddr,
  rdData
);
  input              clk_sys;
  input              wrEn;
  input      [1:0]   wrAddr;
  input      [31:0]  wrData;
  input      [1:0]   rdAddr;
  output reg [31:0]  rdData;

  reg [31:0] mem [0:3];

  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // rx_word_store

// ---- rtl/sysbus_codec_defines.vh ----
// Constants for the system bus flow control and command codec.
`ifndef SYSBUS_CODEC_DEFINES_VH
`define SYSBUS_CODEC_DEFINES_VH
`define REG_CONFIG      4'h0
`define REG_STATUS      4'h1
`define REG_CMD         4'h2
`define REG_DATA        4'h3
`define REG_RXDATA      4'h4
`define REG_RXINFO      4'h5
`define CFG_RESET       8'h00
`define CMD_DATAID_BIT  4
`define CMD_WRITE_BIT   3
`define CMD_BLOCK_BIT   2
`define DID_MORE_BIT    3
`define PAT_D           3'h0
`define PAT_DDX         3'h1
`define PAT_DDXX        3'h2
`define PAT_DXDX        3'h3
`define PAT_DXX         3'h4
`define PAT_DDXXX       3'h5
`define PAT_DXXX        3'h6
`define BS_2WORDS       2'h0
`define BS_4WORDS       2'h1
`define RELEASE_DELAY   2'h2
`endif

// ---- rtl/sysbus_flow_codec.v ----
// System bus data pacing, acceptance, arbitration release and command encoding.
// Function
// - At most one data word crosses the bus per clock cycle.
// - Accept only ext_valid cycles carrying data identifiers, for as long as the agent owns the bus.
// - Outgoing data paced by selected D/x pattern; x holds previous data.
// - Accelerated mode skips the ST_GAP cycle after a write's last data word; ST_IDLE still precedes the next command.
// - endian_select_pin 1 selects big endian, 0 little endian.
// - reverse_endian_bit inverts user-mode byte order.
// - Release latency runs from ext_request rise to proc_owns_bus fall.
// - Commands and data identifiers are five-bit codes on the command bus.
// - Bit 4 zero marks command/address cycle, one marks data identifier.
// - Command bit 3 zero is read, one is write.
// - Read command bit 2 zero single, one block.
// - Block size bits 1:0: zero two words, one four words.
// - Single read bits 1:0 give valid bytes minus one.
// - Write command bit 2 zero single, one block.
// - Single write bits 1:0 give valid bytes minus one.
// - Data identifier bit 3 zero marks last element, one means more.
`timescale 1ns/1ps
`include "sysbus_codec_defines.vh"
module sysbus_flow_codec (
  clk_sys,
  sys_rst,
  regAddr,
  regWrData,
  regWr,
  regRd,
  regRdData,
  endian_select_pin,
  ext_request,
  ext_valid,
  ext_write_ready,
  sysAdIn,
  sysAdOut,
  sysAdOe,
  sysCmdIn,
  sysCmdOut,
  sysCmdOe,
  proc_valid,
  proc_owns_bus,
  bigEndianEff
);
  input              clk_sys;
  input              sys_rst;
  input      [3:0]   regAddr;
  input      [31:0]  regWrData;
  input              regWr;
  input              regRd;
  output reg [31:0]  regRdData;
  input              endian_select_pin;
  input              ext_request;
  input              ext_valid;
  input              ext_write_ready;
  input      [31:0]  sysAdIn;
  output reg [31:0]  sysAdOut;
  output reg         sysAdOe;
  input      [4:0]   sysCmdIn;
  output reg [4:0]   sysCmdOut;
  output reg         sysCmdOe;
  output reg         proc_valid;
  output reg         proc_owns_bus;
  output reg         bigEndianEff;

  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_GAP  = 2'h3;

  // Pins from the far side pass three flops; a change counts once stages 2 and 3 agree.
  reg  [2:0]  reqSync_q;
  reg  [2:0]  evSync_q;
  reg  [2:0]  rdySync_q;
  reg  [2:0]  endSync_q;
  reg         reqF_q;
  reg         evF_q;
  reg         rdyF_q;
  reg         endF_q;
  reg  [31:0] adIn_q;
  reg  [4:0]  cmdIn_q;
  reg  [31:0] adIn2_q;
  reg  [4:0]  cmdIn2_q;
  reg  [31:0] adMid1_q;
  reg  [31:0] adMid2_q;
  reg  [4:0]  cmdMid1_q;
  reg  [4:0]  cmdMid2_q;

  reg  [7:0]  config_q;
  reg         reverseEndian_q;
  reg  [4:0]  cmd_q;
  reg  [31:0] addr_q;
  reg  [31:0] txData_q;
  reg         go_q;
  reg  [1:0]  state_q;
  reg  [2:0]  words_q;
  reg  [2:0]  patPos_q;
  reg  [1:0]  relCnt_q;
  reg         rxActive_q;
  reg  [1:0]  rxCnt_q;
  reg  [2:0]  rxTotal_q;
  reg         rxDone_q;
  reg         rxErr_q;
  reg         rdRxInfo_q;
  reg         rdRxData_q;
  reg  [3:0]  rdAddrLat_q;
  wire [31:0] storeData;

  wire [2:0]  patSel    = config_q[2:0];
  wire        accelMode = config_q[3];
  wire        isWrite   = cmd_q[`CMD_WRITE_BIT];
  wire        isBlock   = cmd_q[`CMD_BLOCK_BIT];
  wire [2:0]  burstLen  = !isBlock ? 3'h1 :
                          (cmd_q[1:0] == `BS_4WORDS) ? 3'h4 : 3'h2;
  wire        lastWord  = (words_q == burstLen - 3'h1);
  wire        rxAccept  = evF_q && cmdIn2_q[`CMD_DATAID_BIT] && !proc_owns_bus;

  reg  [2:0]  patLen;
  reg  [2:0]  patDCnt;
  always @* begin
    patLen  = 3'h1;
    patDCnt = 3'h1;
    case (patSel)
      `PAT_D:     begin patLen = 3'h1; patDCnt = 3'h1; end
      `PAT_DDX:   begin patLen = 3'h3; patDCnt = 3'h2; end
      `PAT_DDXX:  begin patLen = 3'h4; patDCnt = 3'h2; end
      `PAT_DXX:   begin patLen = 3'h3; patDCnt = 3'h1; end
      `PAT_DDXXX: begin patLen = 3'h5; patDCnt = 3'h2; end
      `PAT_DXXX:  begin patLen = 3'h4; patDCnt = 3'h1; end
      default:    begin patLen = 3'h2; patDCnt = 3'h1; end
    endcase
  end
  // DxDx alternates; other patterns put their D cycles first.
  wire dSlot = (patSel == `PAT_DXDX) ? !patPos_q[0] : (patPos_q < patDCnt);

  function [31:0] swapBytes;
    input [31:0] w;
    begin
      swapBytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
  endfunction
  // Effective order is the pin order flipped by the reverse bit.
  wire beEff = endF_q ^ reverseEndian_q;

  rx_word_store u_store (
    .clk_sys (clk_sys),
    .wrEn    (rxAccept),
    .wrAddr  (rxCnt_q),
    .wrData  (adIn2_q),
    .rdAddr  (regAddr[1:0]),
    .rdData  (storeData)
  );

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      reqSync_q <= 3'h0;
      evSync_q  <= 3'h0;
      rdySync_q <= 3'h0;
      endSync_q <= 3'h0;
      reqF_q    <= 1'b0;
      evF_q     <= 1'b0;
      rdyF_q    <= 1'b0;
      endF_q    <= 1'b0;
      adIn_q    <= 32'h0;
      cmdIn_q   <= 5'h0;
      adIn2_q   <= 32'h0;
      cmdIn2_q  <= 5'h0;
      adMid1_q  <= 32'h0;
      adMid2_q  <= 32'h0;
      cmdMid1_q <= 5'h0;
      cmdMid2_q <= 5'h0;
    end else begin
      reqSync_q <= {reqSync_q[1:0], ext_request};
      evSync_q  <= {evSync_q[1:0], ext_valid};
      rdySync_q <= {rdySync_q[1:0], ext_write_ready};
      endSync_q <= {endSync_q[1:0], endian_select_pin};
      if (reqSync_q[1] == reqSync_q[2]) reqF_q <= reqSync_q[2];
      if (evSync_q[1] == evSync_q[2]) evF_q <= evSync_q[2];
      if (rdySync_q[1] == rdySync_q[2]) rdyF_q <= rdySync_q[2];
      if (endSync_q[1] == endSync_q[2]) endF_q <= endSync_q[2];
      // Bus words pass four flops: three filter stages plus the filtered valid register.
      adIn_q    <= sysAdIn;
      cmdIn_q   <= sysCmdIn;
      adMid1_q  <= adIn_q;
      cmdMid1_q <= cmdIn_q;
      adMid2_q  <= adMid1_q;
      cmdMid2_q <= cmdMid1_q;
      adIn2_q   <= adMid2_q;
      cmdIn2_q  <= cmdMid2_q;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      config_q        <= `CFG_RESET;
      reverseEndian_q <= 1'b0;
      cmd_q           <= 5'h0;
      addr_q          <= 32'h0;
      txData_q        <= 32'h0;
      go_q            <= 1'b0;
      regRdData       <= 32'h0;
      rdRxInfo_q      <= 1'b0;
      rdRxData_q      <= 1'b0;
      rdAddrLat_q     <= 4'h0;
    end else begin
      rdRxInfo_q <= regRd && (regAddr == `REG_RXINFO);
      rdRxData_q <= regRd && (regAddr[3:2] == 2'h1) && (regAddr != `REG_RXINFO);
      rdAddrLat_q <= regAddr;
      if (state_q == ST_ADDR) go_q <= 1'b0;
      if (regWr) begin
        case (regAddr)
          `REG_CONFIG: config_q <= regWrData[7:0];
          `REG_STATUS: reverseEndian_q <= regWrData[0];
          `REG_CMD: begin
            // Only the low 4 bits are kept; bit 4 is forced to command.
            cmd_q <= {1'b0, regWrData[3:0]};
            go_q  <= 1'b1;
          end
          `REG_DATA: txData_q <= regWrData;
          default: addr_q <= (regAddr == 4'h6) ? regWrData : addr_q;
        endcase
      end
      regRdData <= 32'h0;
      if (regRd) begin
        case (regAddr)
          `REG_CONFIG: regRdData <= {24'h0, config_q};
          `REG_STATUS: regRdData <= {25'h0, rxErr_q, rxDone_q, state_q, beEff,
                                     proc_owns_bus, reverseEndian_q};
          `REG_CMD:    regRdData <= {27'h0, cmd_q};
          `REG_DATA:   regRdData <= txData_q;
          4'h6:        regRdData <= addr_q;
          `REG_RXINFO: regRdData <= {24'h0, rxErr_q, rxDone_q, 2'h0, rxActive_q, rxTotal_q};
          default:     regRdData <= 32'h0;
        endcase
      end
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q       <= ST_IDLE;
      words_q       <= 3'h0;
      patPos_q      <= 3'h0;
      relCnt_q      <= 2'h0;
      proc_owns_bus <= 1'b1;
      proc_valid    <= 1'b0;
      sysAdOut      <= 32'h0;
      sysAdOe       <= 1'b1;
      sysCmdOut     <= 5'h0;
      sysCmdOe      <= 1'b1;
      bigEndianEff  <= 1'b0;
      rxActive_q    <= 1'b0;
      rxCnt_q       <= 2'h0;
      rxTotal_q     <= 3'h0;
      rxDone_q      <= 1'b0;
      rxErr_q       <= 1'b0;
    end else begin
      bigEndianEff <= beEff;
      proc_valid   <= 1'b0;
      if (!proc_owns_bus) begin
        // Slave: wait for the agent to drop its request, then retake the bus.
        if (!reqF_q) begin
          proc_owns_bus <= 1'b1;
          sysAdOe       <= 1'b1;
          sysCmdOe      <= 1'b1;
        end
      end else if (reqF_q && state_q == ST_IDLE) begin
        // Release latency is the request filter delay plus the fixed relCnt delay once no request is running.
        if (relCnt_q == `RELEASE_DELAY - 2'h1) begin
          proc_owns_bus <= 1'b0;
          sysAdOe       <= 1'b0;
          sysCmdOe      <= 1'b0;
          relCnt_q      <= 2'h0;
        end else begin
          relCnt_q <= relCnt_q + 2'h1;
        end
      end else begin
        relCnt_q <= 2'h0;
        case (state_q)
          ST_IDLE: begin
            if (go_q) state_q <= ST_ADDR;
          end
          ST_ADDR: begin
            sysAdOut   <= addr_q;
            sysCmdOut  <= cmd_q;
            proc_valid <= 1'b1;
            words_q    <= 3'h0;
            patPos_q   <= 3'h0;
            state_q    <= isWrite ? ST_DATA : ST_IDLE;
          end
          ST_DATA: begin
            if (rdyF_q || !isWrite) begin
              if (patPos_q == patLen - 3'h1) patPos_q <= 3'h0;
              else patPos_q <= patPos_q + 3'h1;
              // One word per cycle at most; x cycles hold the last word.
              if (dSlot) begin
                sysAdOut   <= beEff ? txData_q : swapBytes(txData_q);
                sysCmdOut  <= {1'b1, !lastWord, 3'h7};
                proc_valid <= 1'b1;
                words_q    <= words_q + 3'h1;
                if (lastWord) state_q <= accelMode ? ST_IDLE : ST_GAP;
              end
            end
          end
          ST_GAP: state_q <= ST_IDLE;
          default: state_q <= ST_IDLE;
        endcase
      end
      if (rdRxInfo_q) begin
        rxDone_q <= 1'b0;
        rxErr_q  <= 1'b0;
      end
      // A flag raised as the clear lands stays set, but one raised in the read cycle itself is cleared unread.
      if (rxAccept) begin
        rxActive_q <= cmdIn2_q[`DID_MORE_BIT];
        rxCnt_q    <= cmdIn2_q[`DID_MORE_BIT] ? rxCnt_q + 2'h1 : 2'h0;
        rxTotal_q  <= {1'b0, rxCnt_q} + 3'h1;
        if (!cmdIn2_q[`DID_MORE_BIT]) rxDone_q <= 1'b1;
        if (cmdIn2_q[1]) rxErr_q <= 1'b1;
      end
    end
  end

  wire unusedRx = rdRxData_q ^ (|rdAddrLat_q) ^ (|storeData);
endmodule // sysbus_flow_codec

// ---- sim/ext_agent_model.sv ----
// Behavioural external agent facing the processor bus.
`timescale 1ns/1ps
module ext_agent_model (
  input  logic        clk_sys,
  input  logic        proc_owns_bus,
  input  logic [31:0] sysAdOut,
  input  logic        sysAdOe,
  input  logic [4:0]  sysCmdOut,
  input  logic        sysCmdOe,
  output logic        ext_request,
  output logic        ext_valid,
  output logic        ext_write_ready,
  output logic [31:0] sysAdIn,
  output logic [4:0]  sysCmdIn
);
  logic        drv = 1'b0;
  logic [31:0] ad = 32'h0;
  logic [4:0]  cmd = 5'h0;
  // An undriven wire shows the inverse of the last value, so stale data never looks fresh.
  assign sysAdIn = drv ? ad : (sysAdOe ? sysAdOut : ~ad);
  assign sysCmdIn = drv ? cmd : (sysCmdOe ? sysCmdOut : ~cmd);
  initial begin
    ext_request = 1'b0;
    ext_valid = 1'b0;
    ext_write_ready = 1'b1;
  end
  task automatic put(input logic v, input logic [4:0] c, input logic [31:0] a);
    ext_valid <= v;
    cmd <= c;
    ad <= a;
    @(posedge clk_sys);
  endtask
  task automatic session(input logic indep, output int lat);
    lat = 0;
    ext_request <= 1'b1;
    do begin
      @(posedge clk_sys);
      #1;
      lat++;
    end while (proc_owns_bus !== 1'b0 && lat < 30);
    drv <= 1'b1;
    put(1'b0, 5'h10, 32'h0bad_0001);
    put(!indep, 5'h18, 32'h1234_0000);
    put(!indep, 5'h10, 32'h1234_0001);
    drv <= 1'b0;
    ext_valid <= 1'b0;
    ext_request <= 1'b0;
  endtask
endmodule // ext_agent_model

// ---- sim/sysbus_flow_codec_properties.sv ----
// Concurrent checks on the system bus codec ports.
`timescale 1ns/1ps
module sysbus_flow_codec_properties (
  input logic        clk_sys,
  input logic        sys_rst,
  input logic [3:0]  regAddr,
  input logic [31:0] regWrData,
  input logic        regWr,
  input logic        regRd,
  input logic [31:0] regRdData,
  input logic [31:0] sysAdOut,
  input logic        sysAdOe,
  input logic [4:0]  sysCmdOut,
  input logic        sysCmdOe,
  input logic        proc_valid,
  input logic        proc_owns_bus
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_reset_master:
    assert property (disable iff (1'b0) sys_rst |=> proc_owns_bus) else $error("no owner");
  chk_valid_driven:
    assert property (proc_valid |-> proc_owns_bus && sysAdOe && sysCmdOe) else $error("undriven");
  chk_slave_quiet:
    assert property (!proc_owns_bus && $past(!proc_owns_bus) |->
      !sysAdOe && !sysCmdOe && !proc_valid) else $error("slave drives");
  chk_hold_value:
    assert property (proc_owns_bus && $past(proc_owns_bus) && !proc_valid |->
      $stable(sysAdOut) && $stable(sysCmdOut)) else $error("x cycle moved");
  chk_cmd_issue:
    assert property (regWr && regAddr == 4'h2 && proc_owns_bus |->
      ##3 proc_valid && sysCmdOut == {1'b0, $past(regWrData[3:0], 3)}) else $error("cmd");
  chk_id_tail:
    assert property (proc_valid && sysCmdOut[4] |-> sysCmdOut[2:0] == 3'b111)
      else $error("id bits");
  chk_burst_more:
    assert property (proc_valid && sysCmdOut[4:3] == 2'b11 |-> ##[1:5] proc_valid && sysCmdOut[4])
      else $error("burst stops");
  chk_read_idle:
    assert property (!$past(regRd) |-> regRdData == 32'h0) else $error("read data");
endmodule // sysbus_flow_codec_properties

bind sysbus_flow_codec sysbus_flow_codec_properties u_chk (
  .clk_sys, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
  .sysAdOut, .sysAdOe, .sysCmdOut, .sysCmdOe, .proc_valid, .proc_owns_bus
);

// ---- sim/test_sysbus_flow_and_command_codec.sv ----
// Self-checking bench for the system bus flow control and command codec.
`timescale 1ns/1ps
module test_sysbus_flow_and_command_codec;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        endian_select_pin = 1'b1;
  logic [31:0] regRdData, sysAdIn, sysAdOut, d;
  logic [4:0]  sysCmdIn, sysCmdOut;
  logic        sysAdOe, sysCmdOe, proc_valid, proc_owns_bus, bigEndianEff;
  logic        ext_request, ext_valid, ext_write_ready;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          lat;
  logic [4:0]  pm [7] = '{5'h01, 5'h03, 5'h03, 5'h05, 5'h01, 5'h03, 5'h01};
  int          pl [7] = '{1, 3, 4, 4, 3, 5, 4};

  sysbus_flow_codec u_dut (
    .clk_sys, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .endian_select_pin, .ext_request, .ext_valid, .ext_write_ready, .sysAdIn,
    .sysAdOut, .sysAdOe, .sysCmdIn, .sysCmdOut, .sysCmdOe, .proc_valid,
    .proc_owns_bus, .bigEndianEff
  );
  ext_agent_model u_agent (
    .clk_sys, .proc_owns_bus, .sysAdOut, .sysAdOe, .sysCmdOut, .sysCmdOe,
    .ext_request, .ext_valid, .ext_write_ready, .sysAdIn, .sysCmdIn
  );

  always #25 clk_sys = ~clk_sys;

  // The plan needs well under two thousand cycles; this ceiling only catches a hang.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic waitCmd(input logic [4:0] c);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (proc_valid !== 1'b1 && k < 10);
    chk("command", c, sysCmdOut);
  endtask
  task automatic tBurst(input logic [3:0] cfg, input logic [3:0] c, input int n,
                        input logic [4:0] m, input int len, input logic [31:0] e);
    int t, k, first;
    wr(4'h0, {28'h0, cfg});
    wr(4'h3, 32'h1122_3344);
    wr(4'h2, {28'h0, c});
    waitCmd({1'b0, c});
    first = -1;
    k = 0;
    for (t = 0; t < 40 && k < n; t++) begin
      @(posedge clk_sys);
      #1;
      if (first < 0 && proc_valid === 1'b1) first = t;
      if (first >= 0) begin
        chk("pace", m[(t - first) % len], proc_valid);
        if (proc_valid === 1'b1) begin
          k++;
          chk("identifier", {1'b1, k < n, 3'b111}, sysCmdOut);
          chk("data", e, sysAdOut);
        end
      end
    end
    chk("count", n, k);
    rd(4'h1, d);
    chk("gap state", cfg[3] ? 32'h0 : 32'h3, {30'h0, d[4:3]});
  endtask
  task automatic tReset();
    rd(4'h1, d);
    chk("status", 5'b00110, {d[6:5], d[2:0]});
  endtask
  task automatic tEndian();
    endian_select_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk("little", 1'b0, bigEndianEff);
    wr(4'h1, 32'h1);
    repeat (4) @(posedge clk_sys);
    #1 chk("reversed", 1'b1, bigEndianEff);
    wr(4'h1, 32'h0);
  endtask
  task automatic tRead();
    wr(4'h6, 32'h0000_1000);
    wr(4'h2, 32'h4);
    waitCmd(5'h04);
    u_agent.session(1'b0, lat);
    repeat (8) @(posedge clk_sys);
    #1 chk("regained", 1'b1, proc_owns_bus);
    rd(4'h1, d);
    chk("done", 1'b1, d[5]);
    rd(4'h5, d);
    chk("received", 32'h2, {29'h0, d[2:0]});
    chk("last", 1'b0, d[3]);
    @(posedge clk_sys);
    rd(4'h1, d);
    chk("cleared", 1'b0, d[5]);
  endtask
  task automatic tIndep();
    u_agent.session(1'b1, lat);
    chk("latency", 1'b1, lat <= 10);
    repeat (8) @(posedge clk_sys);
    #1 chk("regained", 1'b1, proc_owns_bus);
    rd(4'h1, d);
    chk("ignored", 1'b0, d[5]);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    tReset();
    tEndian();
    tBurst(4'h8, 4'hb, 1, 5'h01, 1, 32'h4433_2211);
    endian_select_pin <= 1'b1;
    for (int p = 0; p < 7; p++)
      tBurst({1'b0, p[2:0]}, 4'hd, 4, pm[p], pl[p], 32'h1122_3344);
    tBurst(4'h0, 4'hc, 2, 5'h01, 1, 32'h1122_3344);
    tRead();
    tIndep();
    conclude();
  end
endmodule // test_sysbus_flow_and_command_codec
